// ### core/eis_sel_mux.sv
// one selector: picks a line of the extended input bus
`timescale 1ns/1ps
`include "eis_params.svh"

module eis_sel_mux (
  // bus and index
  input  wire logic [`EIS_EXT_BUS_W-1:0] bus,
  input  wire logic [`EIS_IDX_W-1:0]     idx,
  // picked line
  output logic                           line
);

  always_comb
  begin
    line = bus[idx];
  end

endmodule

// ### core/eis_top.sv
// configuration extension word and extended input selection behind an AHB-Lite slave
//
// Function
// - bit 21 shows sampling-control register presence
// - bit 20 shows watchpoint inputs usable
// - bits 19:16 give watchpoint input count, max 8
// - bits 15:13 give instrumentation resources, max 4
// - bit 12 set when no data compare
// - bit 11 set when all registers readable
// - bits 10:3 bus size, zero without selectors
// - bits 2:0 give built selector count
// - four 8-bit selector fields, low to high
// - unbuilt selector fields read zero, ignore writes
// - no selectors: whole register zero, ignored
// - extended bus at most 256 lines
// - unusable high selector bits read zero
//
// Implementation choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`include "eis_params.svh"

module eis_top (
  // clock, reset, enable
  input  wire logic                      clk,
  input  wire logic                      rstn,
  input  wire logic                      ce,
  // register bus
  input  wire eis_pkg::eis_ahb_req_t     ahb_req,
  output eis_pkg::eis_ahb_rsp_t          ahb_rsp,
  // extended external input bus, asynchronous
  input  wire logic [`EIS_EXT_BUS_W-1:0] ext_bus_in,
  // selected resource lines
  output logic [`EIS_MAX_SEL-1:0]        ext_res_out
);
  import eis_pkg::*;

  localparam int NUM_SEL = `EIS_NUM_SEL;
  localparam int MAX_SEL = `EIS_MAX_SEL;
  localparam int FW      = `EIS_FIELD_W;
  localparam int BUS_W   = `EIS_EXT_BUS_W;

  // bus width never exceeds 256 lines and fits the index
  initial
  begin
    if (BUS_W > 256 || BUS_W > (1 << `EIS_IDX_W))
    begin
      $error("extended bus too wide");
    end
  end

  // writable bits of the selection register
  function automatic logic [31:0] sel_mask();
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < MAX_SEL; i++)
    begin
      if (i < NUM_SEL)
      begin
        m[i*FW +: FW] = `EIS_FIELD_MASK;
      end
    end
    return m;
  endfunction

  // configuration extension word, fixed at build time
  function automatic logic [31:0] cfg_word();
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`EIS_CCE_SAMPLING_BIT]                 = `EIS_CFG_SAMPLING_CTRL;
    w[`EIS_CCE_WPT_USE_BIT]                  = `EIS_CFG_WPT_USABLE;
    w[`EIS_CCE_WPT_NUM_LSB +: 4]             = `EIS_CFG_WPT_NUM;
    w[`EIS_CCE_INSTR_LSB +: 3]               = `EIS_CFG_INSTR_NUM;
    w[`EIS_CCE_NO_DADDR_BIT]                 = `EIS_CFG_NO_DADDR;
    w[`EIS_CCE_ALL_READ_BIT]                 = `EIS_CFG_ALL_READ;
    if (`EIS_CFG_SEL_NUM != 3'h0)
    begin
      w[`EIS_CCE_BUS_SIZE_LSB +: 8] = `EIS_CFG_BUS_SIZE;
    end
    w[`EIS_CCE_SEL_NUM_LSB +: 3]             = `EIS_CFG_SEL_NUM;
    return w;
  endfunction

  localparam logic [31:0] SEL_MASK = sel_mask();
  localparam logic [31:0] CFG_WORD = cfg_word();

  // bus signals
  logic                   take;
  logic [`EIS_ADDR_W-1:0] addr;
  eis_phase_t             phase_q;
  logic [`EIS_ADDR_W-1:0] waddr_q;
  logic [31:0]            sel_q;
  logic [31:0]            sel_d;
  logic [31:0]            rd_val;
  eis_ahb_rsp_t           rsp_q;

  // input synchroniser
  logic [BUS_W-1:0]       s1_q;
  logic [BUS_W-1:0]       s2_q;
  logic [BUS_W-1:0]       s3_q;
  logic [BUS_W-1:0]       bus_q;

  // routing
  logic [MAX_SEL-1:0]     pick;
  logic [MAX_SEL-1:0]     res_q;

  assign addr = ahb_req.haddr[`EIS_ADDR_W-1:0];
  assign take = ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready;

  // address phase capture; only whole-word writes are accepted
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      phase_q <= EIS_PH_IDLE;
      waddr_q <= '0;
    end
    else if (ce)
    begin
      if (take && ahb_req.hwrite && ahb_req.hsize == `EIS_HSIZE_WORD)
      begin
        phase_q <= EIS_PH_WRITE;
        waddr_q <= addr;
      end
      else if (take && !ahb_req.hwrite)
      begin
        phase_q <= EIS_PH_READ;
        waddr_q <= addr;
      end
      else if (ahb_req.hready)
      begin
        phase_q <= EIS_PH_IDLE;
      end
    end
  end

  // data phase write; unbuilt and unusable bits are masked away
  always_comb
  begin
    sel_d = sel_q;
    if (phase_q == EIS_PH_WRITE && waddr_q == `EIS_OFF_EXT_SEL)
    begin
      sel_d = ahb_req.hwdata & SEL_MASK;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      sel_q <= `EIS_SEL_RESET;
    end
    else if (ce)
    begin
      sel_q <= sel_d;
    end
  end

  // read uses the next value so a write followed at once by a read is seen
  always_comb
  begin
    rd_val = 32'h0000_0000;
    if (addr == `EIS_OFF_CFG_EXT)
    begin
      rd_val = CFG_WORD;
    end
    else if (addr == `EIS_OFF_EXT_SEL)
    begin
      rd_val = sel_d & SEL_MASK;
    end
  end

  // response is zero-wait and always OKAY
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      rsp_q.hrdata    <= `EIS_RDATA_RESET;
      rsp_q.hreadyout <= 1'b1;
      rsp_q.hresp     <= 1'b0;
    end
    else if (ce)
    begin
      rsp_q.hreadyout <= 1'b1;
      rsp_q.hresp     <= 1'b0;
      if (take && !ahb_req.hwrite)
      begin
        rsp_q.hrdata <= rd_val;
      end
      else
      begin
        rsp_q.hrdata <= `EIS_RDATA_RESET;
      end
    end
  end

  assign ahb_rsp = rsp_q;

  // three stages; a line changes once stages two and three agree
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      bus_q <= '0;
    end
    else if (ce)
    begin
      s1_q  <= ext_bus_in;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      bus_q <= (s2_q & s3_q) | (bus_q & (s2_q ^ s3_q));
    end
  end

  // one mux per built selector; the rest stay low
  for (genvar i = 0; i < MAX_SEL; i++)
  begin : g_sel
    if (i < NUM_SEL)
    begin : g_on
      eis_sel_mux u_mux (
        .bus  (bus_q),
        .idx  (sel_q[i*FW +: `EIS_IDX_W]),
        .line (pick[i])
      );
    end
    else
    begin : g_off
      assign pick[i] = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      res_q <= '0;
    end
    else if (ce)
    begin
      res_q <= pick;
    end
  end

  assign ext_res_out = res_q;

endmodule

// ### include/eis_params.svh
// offsets, field positions, reset values and build constants of the input select bank
`ifndef EIS_PARAMS_SVH
`define EIS_PARAMS_SVH

// register byte offsets, low address bits only
`define EIS_ADDR_W            12
`define EIS_OFF_CFG_EXT       12'h000
`define EIS_OFF_EXT_SEL       12'h004

// build choices
`define EIS_MAX_SEL           4
`define EIS_NUM_SEL           3
`define EIS_FIELD_W           8
`define EIS_EXT_BUS_W         64
`define EIS_IDX_W             6
`define EIS_FIELD_MASK        8'h3F

// configuration extension content
`define EIS_CFG_SAMPLING_CTRL 1'b0
`define EIS_CFG_WPT_USABLE    1'b1
`define EIS_CFG_WPT_NUM       4'h4
`define EIS_CFG_INSTR_NUM     3'h0
`define EIS_CFG_NO_DADDR      1'b0
`define EIS_CFG_ALL_READ      1'b1
`define EIS_CFG_BUS_SIZE      8'h40
`define EIS_CFG_SEL_NUM       3'h3

// configuration extension field positions
`define EIS_CCE_SAMPLING_BIT  21
`define EIS_CCE_WPT_USE_BIT   20
`define EIS_CCE_WPT_NUM_LSB   16
`define EIS_CCE_INSTR_LSB     13
`define EIS_CCE_NO_DADDR_BIT  12
`define EIS_CCE_ALL_READ_BIT  11
`define EIS_CCE_BUS_SIZE_LSB  3
`define EIS_CCE_SEL_NUM_LSB   0

// reset values
`define EIS_SEL_RESET         32'h0000_0000
`define EIS_RDATA_RESET       32'h0000_0000

// bus encodings
`define EIS_HSIZE_WORD        3'h2

`endif

// ### include/eis_pkg.sv
// types shared by the input select bank
package eis_pkg;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } eis_ahb_req_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } eis_ahb_rsp_t;

  typedef enum logic [1:0] {
    EIS_PH_IDLE,
    EIS_PH_WRITE,
    EIS_PH_READ
  } eis_phase_t;

endpackage

// ### tb/eis_props.sv
// assertions on the input select bank ports
`timescale 1ns/1ps
`include "eis_params.svh"
module eis_props (
  // watched ports
  input wire logic                      clk,
  input wire logic                      rstn,
  input wire logic                      ce,
  input wire eis_pkg::eis_ahb_req_t     ahb_req,
  input wire eis_pkg::eis_ahb_rsp_t     ahb_rsp,
  input wire logic [`EIS_EXT_BUS_W-1:0] ext_bus_in,
  input wire logic [`EIS_MAX_SEL-1:0]   ext_res_out
);
  import eis_pkg::*;
  logic tk;
  logic rd_c;
  logic rd_s;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn);
  assign tk = ahb_req.hsel & ahb_req.htrans[1] & ahb_req.hready & ce & !ahb_req.hwrite;
  assign rd_c = tk && ahb_req.haddr[11:0] == `EIS_OFF_CFG_EXT;
  assign rd_s = tk && ahb_req.haddr[11:0] == `EIS_OFF_EXT_SEL;
  chk_smp_absent: assert property (rd_c |=> ahb_rsp.hrdata[21] == 1'b0)
    else $error("sampling bit wrong");
  chk_wpt_usable: assert property (rd_c |=> ahb_rsp.hrdata[20] == 1'b1)
    else $error("watchpoint use bit wrong");
  chk_wpt_count: assert property (rd_c |=> ahb_rsp.hrdata[19:16] == 4'h4)
    else $error("watchpoint count wrong");
  chk_instr_count: assert property (rd_c |=> ahb_rsp.hrdata[15:13] <= 3'h4)
    else $error("instrumentation count too big");
  chk_daddr_flag: assert property (rd_c |=> ahb_rsp.hrdata[12] == 1'b0)
    else $error("data compare flag wrong");
  chk_sel_count: assert property (rd_c |=> ahb_rsp.hrdata[11:0] == 12'hA03)
    else $error("bus size or selector count wrong");
  chk_sel_unused: assert property (rd_s |=> (ahb_rsp.hrdata & 32'hFFC0C0C0) == 32'h0)
    else $error("unbuilt selector bits set");
  chk_res_top_zero: assert property (ext_res_out[3] == 1'b0)
    else $error("unbuilt selector output set");
endmodule

// ### tb/eis_top_tb.sv
// self-checking bench for the input select bank
`timescale 1ns/1ps
`include "eis_params.svh"
module eis_top_tb;
  import eis_pkg::*;
  logic                      clk = 1'b0;
  logic                      rstn = 1'b0;
  logic [31:0]               haddr = 32'h0;
  logic [1:0]                htrans = 2'h0;
  logic                      hwrite = 1'b0;
  logic [31:0]               hwdata = 32'h0;
  logic [`EIS_EXT_BUS_W-1:0] bus = '0;
  eis_ahb_rsp_t              rsp;
  eis_ahb_req_t              req;
  logic [`EIS_MAX_SEL-1:0]   res;
  logic [31:0]               rd;
  logic [31:0]               d;
  logic [31:0]               sel_m;
  int                        mismatches = 0;
  int                        comparisons = 0;

  assign req = '{1'b1, haddr, htrans, hwrite, `EIS_HSIZE_WORD, hwdata, rsp.hreadyout};
  always #25 clk = ~clk;

  eis_top i_dut (
    .clk         (clk),
    .rstn        (rstn),
    .ce          (1'b1),
    .ahb_req     (req),
    .ahb_rsp     (rsp),
    .ext_bus_in  (bus),
    .ext_res_out (res)
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one single transfer; waits on hready, never on a fixed count
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] wd);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (rsp.hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (rsp.hreadyout !== 1'b1);
    rd = rsp.hrdata;
  endtask

  task automatic report_and_stop;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (5000) @(posedge clk);
    mismatches++;
    report_and_stop();
  end

  initial
  begin
    void'($urandom(32'h74DBC885));
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    sel_m = 32'h0;
    xfer(32'h4, 1'b0, 32'h0);
    chk(rd, sel_m);
    // read-only word must ignore the write
    xfer(32'h0, 1'b1, 32'hFFFFFFFF);
    xfer(32'h0, 1'b0, 32'h0);
    chk(rd, 32'h00140A03);
    xfer(32'h8, 1'b1, 32'hFFFFFFFF);
    xfer(32'h8, 1'b0, 32'h0);
    chk(rd, 32'h0);
    repeat (20)
    begin
      d = $urandom;
      xfer(32'h4, 1'b1, d);
      sel_m = d & 32'h003F3F3F;
      xfer(32'h4, 1'b0, 32'h0);
      chk(rd, sel_m);
      chk({30'h0, rsp.hreadyout, rsp.hresp}, 32'h2);
      bus <= {$urandom, $urandom};
      repeat (6) @(posedge clk);
      chk({28'h0, res}, {29'h0, bus[sel_m[21:16]], bus[sel_m[13:8]], bus[sel_m[5:0]]});
    end
    report_and_stop();
  end
endmodule

bind eis_top eis_props i_props (
  .clk         (clk),
  .rstn        (rstn),
  .ce          (ce),
  .ahb_req     (ahb_req),
  .ahb_rsp     (ahb_rsp),
  .ext_bus_in  (ext_bus_in),
  .ext_res_out (ext_res_out)
);
